// >>> shared/tlm_pkg.sv
// constants, field layout and lookup tables of the twilight limit monitor
// assumes a single 40 MHz clock and a 32-bit AHB-Lite register port
package tlm_pkg;

  // clock and one-second timebase
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_PERIOD_NS = 1000000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THR = 8'h04;
  localparam logic [7:0] ADDR_DLY = 8'h08;
  localparam logic [7:0] ADDR_EXT = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // control fields
  localparam int CTRL_TWI_BIT = 0;
  localparam int CTRL_BOTH_BIT = 1;
  localparam int CTRL_SOC_BIT = 2;
  localparam int CTRL_SRC_LSB = 4;
  // threshold fields
  localparam int THR_SEL_LSB = 0;
  localparam int HYS_SEL_LSB = 8;
  localparam int MODE_LSB = 16;
  // delay and cyclic fields
  localparam int DLY_ON_LSB = 0;
  localparam int DLY_OFF_LSB = 8;
  localparam int CYC_LSB = 16;
  // status bits
  localparam int STAT_STATE_BIT = 0;
  localparam int STAT_TARGET_BIT = 1;
  localparam int STAT_ON_BIT = 2;
  localparam int STAT_OFF_BIT = 3;
  localparam int STAT_PRESENT_BIT = 4;
  localparam int STAT_QUIET_BIT = 5;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] THR_RST = 32'h0000_0000;
  localparam logic [31:0] DLY_RST = 32'h0000_0000;
  localparam logic [15:0] EXT_RST = 16'h0000;

  // setting ranges
  localparam logic [6:0] CYC_MAX = 7'h78;
  localparam logic [3:0] CYC_UNIT_SEC = 4'ha;
  localparam logic [4:0] THR_SEL_MAX = 5'h1a;
  localparam logic [3:0] DLY_SEL_MAX = 4'hd;
  localparam logic [15:0] THR_BASE_LUX = 16'h000a;
  localparam logic [15:0] THR_STEP_LUX = 16'h0019;
  localparam logic [15:0] HYS_STEP_LUX = 16'h0032;
  localparam logic [17:0] RANGE_LUX = 18'h002a2;
  localparam logic [17:0] PERCENT = 18'h00064;

  typedef enum logic [1:0] {
    TLM_SRC_PARAM, TLM_SRC_EXT16, TLM_SRC_EXT8, TLM_SRC_SPARE
  } tlm_src_type;

  // crossing actions: first condition, then the opposite one
  typedef enum logic [3:0] {
    TLM_EXC_ON_UND_OFF, TLM_EXC_OFF_UND_ON,
    TLM_UND_ON_EXC_OFF, TLM_UND_OFF_EXC_ON,
    TLM_EXC_ON_UND_NONE, TLM_EXC_OFF_UND_NONE,
    TLM_UND_ON_EXC_NONE, TLM_UND_OFF_EXC_NONE,
    TLM_EXC_NONE_UND_OFF, TLM_EXC_NONE_UND_ON,
    TLM_UND_NONE_EXC_OFF, TLM_UND_NONE_EXC_ON
  } tlm_mode_type;

  // threshold: 10 lux, then 25 lux steps up to 650 lux
  function automatic logic [15:0] tlm_thr_lux(input logic [4:0] sel);
    logic [4:0] s;
    s = (sel > THR_SEL_MAX) ? THR_SEL_MAX : sel;
    if (s == 5'h00) begin
      return THR_BASE_LUX;
    end
    return 16'(THR_STEP_LUX * 16'(s));
  endfunction : tlm_thr_lux

  // hysteresis: none, 5, 10, 25, 50, then 100 to 600 in 50 lux steps
  function automatic logic [15:0] tlm_hys_lux(input logic [3:0] sel);
    case (sel)
      4'h0: return 16'h0000;
      4'h1: return 16'h0005;
      4'h2: return 16'h000a;
      4'h3: return 16'h0019;
      default: return 16'(HYS_STEP_LUX * 16'(sel - 4'h3));
    endcase
  endfunction : tlm_hys_lux

  // delay in seconds: none, 1 s ... 60 min
  function automatic logic [11:0] tlm_delay_sec(input logic [3:0] sel);
    case (sel)
      4'h0: return 12'h000;
      4'h1: return 12'h001;
      4'h2: return 12'h003;
      4'h3: return 12'h005;
      4'h4: return 12'h00a;
      4'h5: return 12'h00f;
      4'h6: return 12'h01e;
      4'h7: return 12'h03c;
      4'h8: return 12'h0b4;
      4'h9: return 12'h12c;
      4'ha: return 12'h258;
      4'hb: return 12'h384;
      4'hc: return 12'h708;
      default: return 12'he10;
    endcase
  endfunction : tlm_delay_sec

endpackage : tlm_pkg

// >>> design/tlm_tick_gen.sv
// one-cycle enable pulse once per second of the system clock
// assumes hclk at the rate for which TICK_CYCLES was derived
`timescale 1ns/100ps
`default_nettype none
module tlm_tick_gen #(
  parameter int unsigned TICK_CYCLES = tlm_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  localparam int W = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("tick period must be at least two cycles");
  end

  logic [W-1:0] div_reg;

  // free running divider, wraps once per second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
    end else if (div_reg == W'(TICK_CYCLES - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign tick = (div_reg == W'(TICK_CYCLES - 1));
endmodule : tlm_tick_gen
`default_nettype wire

// >>> design/tlm_delay_timer.sv
// seconds delay timer: counts ticks while run is high, clears when it drops
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none
module tlm_delay_timer #(
  parameter int W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic busy,
  output logic done
);
  if (W < 12) begin : g_bad_width
    $error("delay timer too narrow for 60 min");
  end

  logic [W-1:0] count_reg;

  // dropping run throws the elapsed time away
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
    end else if (!run) begin
      count_reg <= '0;
    end else if (tick && count_reg < limit) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign done = run && (count_reg >= limit);
  assign busy = run && !done;
endmodule : tlm_delay_timer
`default_nettype wire

// >>> design/tlm_monitor.sv
// assumes an AHB-Lite master on hclk and a measurement from same-clock logic
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tlm_monitor #(
  parameter int unsigned TICK_CYCLES = tlm_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] meas_lux,
  output logic limit_state,
  output logic telegram_send,
  output logic telegram_value
);
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ---------------- bus slave ----------------
  logic [31:0] ctrl_reg;
  logic [31:0] thr_reg;
  logic [31:0] dly_reg;
  logic [15:0] ext_reg;
  logic [31:0] rdata_reg;
  logic [7:0] wr_addr_reg;
  logic wr_pend_reg;
  logic [31:0] status;
  logic access;

  assign access = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // address phase: catch write target, prepare read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= access && hwrite && hsize == HSIZE_WORD;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (access && !hwrite) begin
      case (haddr[7:0])
        tlm_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
        tlm_pkg::ADDR_THR: rdata_reg <= thr_reg;
        tlm_pkg::ADDR_DLY: rdata_reg <= dly_reg;
        tlm_pkg::ADDR_EXT: rdata_reg <= {16'h0000, ext_reg};
        tlm_pkg::ADDR_STAT: rdata_reg <= status;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // data phase: store the write, unmapped offsets are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= tlm_pkg::CTRL_RST;
      thr_reg <= tlm_pkg::THR_RST;
      dly_reg <= tlm_pkg::DLY_RST;
      ext_reg <= tlm_pkg::EXT_RST;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        tlm_pkg::ADDR_CTRL: ctrl_reg <= hwdata;
        tlm_pkg::ADDR_THR: thr_reg <= hwdata;
        tlm_pkg::ADDR_DLY: dly_reg <= hwdata;
        tlm_pkg::ADDR_EXT: ext_reg <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // ---------------- configuration decode ----------------
  logic present;
  logic soc_en;
  tlm_pkg::tlm_src_type src;
  tlm_pkg::tlm_mode_type mode;
  logic [6:0] cyc_set;
  logic [10:0] cyc_period;
  logic [11:0] on_sec;
  logic [11:0] off_sec;

  assign present = ctrl_reg[tlm_pkg::CTRL_TWI_BIT]
                   && ctrl_reg[tlm_pkg::CTRL_BOTH_BIT];
  assign soc_en = ctrl_reg[tlm_pkg::CTRL_SOC_BIT];
  assign src = tlm_pkg::tlm_src_type'(ctrl_reg[tlm_pkg::CTRL_SRC_LSB +: 2]);
  assign mode = tlm_pkg::tlm_mode_type'(thr_reg[tlm_pkg::MODE_LSB +: 4]);
  // settings above 120 are clipped to the top of the range
  assign cyc_set = (dly_reg[tlm_pkg::CYC_LSB +: 7] > tlm_pkg::CYC_MAX)
                   ? tlm_pkg::CYC_MAX : dly_reg[tlm_pkg::CYC_LSB +: 7];
  assign cyc_period = 11'(cyc_set) * 11'(tlm_pkg::CYC_UNIT_SEC);
  assign on_sec = tlm_pkg::tlm_delay_sec(
    thr_sel_clip(dly_reg[tlm_pkg::DLY_ON_LSB +: 4]));
  assign off_sec = tlm_pkg::tlm_delay_sec(
    thr_sel_clip(dly_reg[tlm_pkg::DLY_OFF_LSB +: 4]));

  function automatic logic [3:0] thr_sel_clip(input logic [3:0] sel);
    return (sel > tlm_pkg::DLY_SEL_MAX) ? tlm_pkg::DLY_SEL_MAX : sel;
  endfunction : thr_sel_clip

  // ---------------- threshold and hysteresis ----------------
  logic [16:0] thr_lux;
  logic [16:0] hys_lux;
  logic [17:0] pct_lux;

  // 1-byte object is a percentage of the measuring range top
  assign pct_lux = 18'((18'(ext_reg[7:0]) * tlm_pkg::RANGE_LUX)
                       / tlm_pkg::PERCENT);

  // threshold source selection
  always_comb begin
    case (src)
      tlm_pkg::TLM_SRC_EXT16: thr_lux = {1'b0, ext_reg};
      tlm_pkg::TLM_SRC_EXT8: thr_lux = pct_lux[16:0];
      default: thr_lux = {1'b0, tlm_pkg::tlm_thr_lux(
                 thr_reg[tlm_pkg::THR_SEL_LSB +: 5])};
    endcase
  end

  assign hys_lux = {1'b0, tlm_pkg::tlm_hys_lux(
                     thr_reg[tlm_pkg::HYS_SEL_LSB +: 4])};

  // ---------------- comparator and crossing action ----------------
  logic [16:0] meas_w;
  logic above;
  logic below;
  logic below_hys;
  logic above_hys;
  logic exc_based;
  logic val_a;
  logic tel_a;
  logic tel_b;
  logic ev_a;
  logic ev_b;
  logic quiet;
  logic target_reg;

  assign meas_w = {1'b0, meas_lux};
  assign above = meas_w > thr_lux;
  assign below = meas_w < thr_lux;
  // written as a sum so a wide hysteresis cannot wrap below zero
  assign below_hys = 18'(meas_w) + 18'(hys_lux) < 18'(thr_lux);
  assign above_hys = 18'(meas_w) > 18'(thr_lux) + 18'(hys_lux);

  // mode decode: exceed or undershoot based, values and silent sides
  always_comb begin
    exc_based = 1'b1;
    val_a = 1'b1;
    tel_a = 1'b1;
    tel_b = 1'b1;
    case (mode)
      tlm_pkg::TLM_EXC_ON_UND_OFF: ;
      tlm_pkg::TLM_EXC_OFF_UND_ON: val_a = 1'b0;
      tlm_pkg::TLM_UND_ON_EXC_OFF: exc_based = 1'b0;
      tlm_pkg::TLM_UND_OFF_EXC_ON: begin
        exc_based = 1'b0;
        val_a = 1'b0;
      end
      tlm_pkg::TLM_EXC_ON_UND_NONE: tel_b = 1'b0;
      tlm_pkg::TLM_EXC_OFF_UND_NONE: begin
        val_a = 1'b0;
        tel_b = 1'b0;
      end
      tlm_pkg::TLM_UND_ON_EXC_NONE: begin
        exc_based = 1'b0;
        tel_b = 1'b0;
      end
      tlm_pkg::TLM_UND_OFF_EXC_NONE: begin
        exc_based = 1'b0;
        val_a = 1'b0;
        tel_b = 1'b0;
      end
      tlm_pkg::TLM_EXC_NONE_UND_OFF: tel_a = 1'b0;
      tlm_pkg::TLM_EXC_NONE_UND_ON: begin
        val_a = 1'b0;
        tel_a = 1'b0;
      end
      tlm_pkg::TLM_UND_NONE_EXC_OFF: begin
        exc_based = 1'b0;
        tel_a = 1'b0;
      end
      tlm_pkg::TLM_UND_NONE_EXC_ON: begin
        exc_based = 1'b0;
        val_a = 1'b0;
        tel_a = 1'b0;
      end
      default: begin
        tel_a = 1'b0;
        tel_b = 1'b0;
      end
    endcase
  end

  assign ev_a = exc_based ? above : below;
  assign ev_b = exc_based ? below_hys : above_hys;
  // silent condition holding: no cyclic telegram; change telegrams still go out
  assign quiet = (ev_a && !tel_a) || (ev_b && !tel_b);

  // desired state from the comparator, held between crossings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_reg <= 1'b0;
    end else if (!present) begin
      target_reg <= 1'b0;
    end else if (ev_a && tel_a) begin
      target_reg <= val_a;
    end else if (ev_b && tel_b) begin
      target_reg <= !val_a;
    end
  end

  // ---------------- delays and accepted state ----------------
  logic tick;
  logic state_reg;
  logic state_next;
  logic on_run;
  logic off_run;
  logic on_busy;
  logic off_busy;
  logic on_done;
  logic off_done;

  tlm_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // a timer only runs while target and accepted state differ
  assign on_run = present && target_reg && !state_reg;
  assign off_run = present && !target_reg && state_reg;

  tlm_delay_timer #(.W(12)) u_on_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(on_run),
    .tick(tick),
    .limit(on_sec),
    .busy(on_busy),
    .done(on_done)
  );

  tlm_delay_timer #(.W(12)) u_off_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(off_run),
    .tick(tick),
    .limit(off_sec),
    .busy(off_busy),
    .done(off_done)
  );

  // accepted state moves only when its delay has run out, or clears while the function is absent
  always_comb begin
    state_next = state_reg;
    if (!present) begin
      state_next = 1'b0;
    end else if (on_done) begin
      state_next = 1'b1;
    end else if (off_done) begin
      state_next = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------- transmission ----------------
  logic [10:0] cyc_sec_reg;
  logic cyc_fire;
  logic chg;

  // cyclic repetition counter in seconds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_sec_reg <= 11'h000;
    end else if (!present || cyc_set == 7'h00 || cyc_fire) begin
      cyc_sec_reg <= 11'h000;
    end else if (tick) begin
      cyc_sec_reg <= cyc_sec_reg + 11'h001;
    end
  end

  assign cyc_fire = tick && present && cyc_set != 7'h00
                    && cyc_sec_reg >= cyc_period - 11'h001;
  assign chg = state_next != state_reg;

  // one pulse per telegram, value is always the accepted state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      telegram_send <= 1'b0;
      telegram_value <= 1'b0;
    end else begin
      telegram_send <= present && ((chg && soc_en)
                       || (cyc_fire && !quiet));
      telegram_value <= state_next;
    end
  end

  assign limit_state = state_reg;

  assign status = {26'h0000000, quiet, present, off_busy, on_busy,
                   target_reg, state_reg};

  // ---------------- checks ----------------
  a_off_after_delay: assert property (
    $fell(state_reg) && $past(present) |-> $past(off_done))
    else $error("limit state fell before the switch-off delay");

  a_cyc_holds_one: assert property (
    cyc_fire && !quiet && off_busy |=> telegram_send && telegram_value)
    else $error("cyclic telegram during switch-off delay not 1");

  a_quiet_no_cyc: assert property (
    quiet && cyc_fire && !(chg && soc_en) |=> !telegram_send)
    else $error("cyclic telegram sent in a silent condition");

  a_no_change_send: assert property (
    chg && !soc_en && !cyc_fire |=> !telegram_send)
    else $error("change sent with send-on-change off");

  a_cyc_sends: assert property (
    cyc_fire && !quiet |=> telegram_send
      ##1 (!telegram_send || $past(chg && soc_en)))
    else $error("cyclic telegram missing or not a pulse");

  a_change_sent: assert property (
    present && chg && soc_en |=> telegram_send
      && telegram_value == $past(state_next))
    else $error("state change not sent");

  a_never_send: assert property (
    !soc_en && cyc_set == 7'h00 |=> !telegram_send)
    else $error("telegram sent with all sending off");

  a_on_after_delay: assert property (
    $rose(state_reg) |-> $past(on_done) && $past(target_reg))
    else $error("limit state rose before the switch-on delay");

  a_cyc_period: assert property (
    cyc_fire |-> cyc_sec_reg == cyc_period - 11'h001)
    else $error("cyclic period not setting times ten seconds");

  a_absent_idle: assert property (
    !present |=> !telegram_send && !state_reg)
    else $error("output active while the function is absent");

  a_cancel_keeps: assert property (
    $past(on_busy || off_busy) && $changed(target_reg)
      |-> $stable(state_reg) && !on_busy && !off_busy)
    else $error("cancelled switch-on delay changed the state");

endmodule : tlm_monitor
`default_nettype wire

// >>> tb/tlm_bus_rx.sv
// receiving end of the building bus: latches each limit-state telegram
// assumes telegrams arrive as one-cycle pulses on hclk
`timescale 1ns/100ps
`default_nettype none
module tlm_bus_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic telegram_send,
  input wire logic telegram_value,
  output logic rx_strobe,
  output logic rx_value
);
  // take a telegram one cycle late; idle value toggles so it is never stale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_strobe <= 1'b0;
      rx_value <= 1'b0;
    end else begin
      rx_strobe <= telegram_send;
      rx_value <= telegram_send ? telegram_value : ~rx_value;
    end
  end
endmodule : tlm_bus_rx
`default_nettype wire

// >>> tb/twilight_limit_monitor_bench.sv
// self-checking bench of the twilight limit monitor
// assumes a fast tick (4 cycles a second) and the bus receiver model
`timescale 1ns/100ps
`default_nettype none
module twilight_limit_monitor_bench;
  logic hclk;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] meas_lux = 16'h0;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic limit_state;
  wire logic telegram_send;
  wire logic telegram_value;
  wire logic rx_strobe;
  wire logic rx_value;
  int failures = 0;
  int n_checks = 0;
  int t_el;
  int seed;
  logic [31:0] rd;
  logic q[$];

  tlm_monitor #(.TICK_CYCLES(4)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .meas_lux(meas_lux), .limit_state(limit_state),
    .telegram_send(telegram_send), .telegram_value(telegram_value));
  tlm_bus_rx i_rx (.hclk(hclk), .hresetn(hresetn),
    .telegram_send(telegram_send), .telegram_value(telegram_value),
    .rx_strobe(rx_strobe), .rx_value(rx_value));

  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // one single AHB-Lite transfer, waits on hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk

  // new measurement; note expected telegrams, wait until all are seen
  task step(input logic [15:0] v, input int e1, input int e2, input int n);
    if (e1 >= 0) q.push_back(e1[0]);
    if (e2 >= 0) q.push_back(e2[0]);
    meas_lux <= v;
    t_el = 0;
    for (int k = 0; k < n; k++) begin
      @(posedge hclk);
      #1;
      t_el++;
      if (e1 >= 0 && q.size() == 0) break;
    end
    if (q.size() != 0) begin
      check(32'(q.size()), 32'h0);
      q.delete();
    end
    @(posedge hclk);
  endtask : step

  // compare each received telegram with the oldest note
  always @(posedge hclk) begin
    if (rx_strobe === 1'b1) begin
      if (q.size() == 0) check(32'h1, 32'h0);
      else check({31'h0, rx_value}, {31'h0, q.pop_front()});
    end
  end

  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge hclk);
    failures++;
    give_verdict();
  end

  initial begin
    seed = 32'hd41d9783;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0);
    ahb(1'b1, 8'h14, 32'hffffffff);
    rchk(8'h14, 32'h0);
    ahb(1'b1, 8'h00, 32'h7);
    ahb(1'b1, 8'h04, 32'h204);
    rchk(8'h04, 32'h204);
    rchk(8'h10, 32'h10);
    step(16'd100, -1, -1, 10);
    step(16'd101, 1, -1, 10);
    step(16'd90, -1, -1, 10);
    step(16'd89, 0, -1, 10);
    ahb(1'b1, 8'h04, 32'h20204);
    step(16'd89, 1, -1, 10);
    step(16'd110, -1, -1, 10);
    step(16'd111, 0, -1, 10);
    ahb(1'b1, 8'h04, 32'h40204);
    step(16'd111, 1, -1, 10);
    step(16'd50, -1, -1, 10);
    check({31'h0, limit_state}, 32'h1);
    ahb(1'b1, 8'h08, 32'h10000);
    step(16'd50, -1, -1, 100);
    step(16'd111, 1, -1, 50);
    step(16'd111, 1, -1, 50);
    check(32'(t_el >= 37 && t_el <= 41), 32'h1);
    ahb(1'b1, 8'h04, 32'h204);
    ahb(1'b1, 8'h08, 32'h10500);
    step(16'd111, 1, -1, 50);
    step(16'd50, 1, 0, 90);
    check(32'(t_el >= 56), 32'h1);
    ahb(1'b1, 8'h08, 32'h0);
    step(16'd111, 1, -1, 10);
    ahb(1'b1, 8'h08, 32'h300);
    step(16'd50, -1, -1, 8);
    step(16'd111, -1, -1, 40);
    check({31'h0, limit_state}, 32'h1);
    ahb(1'b1, 8'h08, 32'h0);
    step(16'd50, 0, -1, 10);
    ahb(1'b1, 8'h08, 32'h10005);
    step(16'd50, 0, -1, 50);
    step(16'd111, 0, 1, 90);
    check(32'(t_el >= 56), 32'h1);
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b1, 8'h00, 32'h3);
    step(16'd50, -1, -1, 10);
    check({31'h0, limit_state}, 32'h0);
    step(16'd111, -1, -1, 10);
    check({31'h0, limit_state}, 32'h1);
    step(16'd50, -1, -1, 10);
    ahb(1'b1, 8'h0c, 32'h12c);
    rchk(8'h0c, 32'h12c);
    ahb(1'b1, 8'h00, 32'h17);
    step(16'd301, 1, -1, 10);
    step(16'd289, 0, -1, 10);
    ahb(1'b1, 8'h00, 32'h27);
    ahb(1'b1, 8'h0c, 32'h32);
    step(16'd337, -1, -1, 10);
    step(16'd338, 1, -1, 10);
    step(16'd326, 0, -1, 10);
    step(16'd338, 1, -1, 10);
    // remaining crossing modes on the fixed 100 lux threshold, 10 lux hyst
    ahb(1'b1, 8'h00, 32'h7);
    ahb(1'b1, 8'h04, 32'h10204);
    step(16'd338, 0, -1, 10);
    step(16'd50, 1, -1, 10);
    ahb(1'b1, 8'h04, 32'h30204);
    step(16'd50, 0, -1, 10);
    step(16'd111, 1, -1, 10);
    ahb(1'b1, 8'h04, 32'h80204);
    step(16'd111, -1, -1, 10);
    step(16'd50, 0, -1, 10);
    ahb(1'b1, 8'h04, 32'h90204);
    step(16'd50, 1, -1, 10);
    step(16'd111, -1, -1, 10);
    check({31'h0, limit_state}, 32'h1);
    ahb(1'b1, 8'h04, 32'ha0204);
    step(16'd111, 0, -1, 10);
    step(16'd50, -1, -1, 10);
    ahb(1'b1, 8'h04, 32'hb0204);
    step(16'd111, 1, -1, 10);
    ahb(1'b1, 8'h04, 32'h50204);
    step(16'd111, 0, -1, 10);
    step(16'd50, -1, -1, 10);
    ahb(1'b1, 8'h04, 32'h60204);
    step(16'd50, 1, -1, 10);
    step(16'd111, -1, -1, 10);
    ahb(1'b1, 8'h04, 32'h70204);
    step(16'd50, 0, -1, 10);
    ahb(1'b1, 8'h04, 32'hc0204);
    step(16'd111, -1, -1, 10);
    check({31'h0, limit_state}, 32'h0);
    ahb(1'b1, 8'h00, 32'h25);
    for (int i = 0; i < 8; i++) begin
      step(16'($random(seed)), -1, -1, 4);
      check({31'h0, limit_state}, 32'h0);
    end
    give_verdict();
  end
endmodule : twilight_limit_monitor_bench
`default_nettype wire
